// ---- dv/usb_device_dma_byte_counter_props.sv ----
`timescale 1ns/100ps
// =============================================================
// Device-side answers on the shared bus.
module usb_device_dma_byte_counter_props (
   input wire logic CORE_CLK_I,
   input wire logic RESET_I,
   input wire logic cmd_phase,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic rdata_valid,
   input wire logic eot,
   input wire logic dma_active
);
   logic pend_q;
   logic [7:0] cmd_q;
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (RESET_I);
   always_ff @(posedge CORE_CLK_I or posedge RESET_I)
   begin
      if (RESET_I) pend_q <= 1'b0;
      else if (cmd_phase && wr_strobe) pend_q <= wdata[7:0] != 8'hf6;
      else if (wr_strobe || rd_strobe) pend_q <= 1'b0;
   end
   always_ff @(posedge CORE_CLK_I or posedge RESET_I)
   begin
      if (RESET_I) cmd_q <= 8'h00;
      else if (cmd_phase && wr_strobe) cmd_q <= wdata[7:0];
   end
   read_answer_a: assert property (
      pend_q && rd_strobe && !cmd_phase |=> rdata_valid)
      else $error("read answer missing");
   valid_cause_a: assert property (
      rdata_valid |-> $past(pend_q && rd_strobe))
      else $error("read answer without request");
   valid_pulse_a: assert property (
      rdata_valid |=> !rdata_valid)
      else $error("read answer longer than one cycle");
   eot_enable_a: assert property (
      eot |-> $past(dma_active))
      else $error("end of transfer while disabled");
   soft_reset_a: assert property (
      cmd_phase && wr_strobe && wdata[7:0] == 8'hf6 |->
      ##[1:3] (!dma_active && !eot && rdata == 16'h0000))
      else $error("reset command left state");
   enable_rise_a: assert property (
      $rose(dma_active) |-> $past(wr_strobe) || $past(wr_strobe, 2))
      else $error("enable rose without write");
   unknown_zero_a: assert property (
      rdata_valid && cmd_q != 8'hf1 && cmd_q != 8'hf3 |->
      rdata == 16'h0000)
      else $error("unknown read not zero");
   rdata_hold_a: assert property (
      $changed(rdata) |-> rdata_valid || rdata == 16'h0000)
      else $error("read data changed between reads");
   cover property (rdata_valid);
   cover property (eot);
   cover property (cmd_phase && wr_strobe && wdata[7:0] == 8'hf6);
endmodule : usb_device_dma_byte_counter_props

// ---- dv/usb_device_dma_byte_counter_tb_top.sv ----
`timescale 1ns/100ps
// =============================================================
// Microprocessor end drives the device end across the bus.
module usb_device_dma_byte_counter_tb_top;
   logic clk, rst, req, byte_in, bus_rst, busy, done, en, eot_out;
   logic [7:0] cmd;
   logic [15:0] din, dout, remain;
   int mismatches, n_tests;
   dma_cmd_if bus_if ();
   dma_counter_dev u_dma_counter_dev (.CORE_CLK_I(clk), .RESET_I(rst),
      .USB_BUS_RESET_I(bus_rst), .bus(bus_if), .DMA_ENABLE_O(en),
      .REMAINING_O(remain));
   dma_counter_host u_dma_counter_host (.CORE_CLK_I(clk), .RESET_I(rst),
      .REQ_I(req), .CMD_I(cmd), .DATA_I(din), .BYTE_I(byte_in),
      .bus(bus_if), .BUSY_O(busy), .DONE_O(done), .DATA_O(dout),
      .EOT_O(eot_out));
   usb_device_dma_byte_counter_props u_props (.CORE_CLK_I(clk),
      .RESET_I(rst), .cmd_phase(bus_if.cmd_phase),
      .wr_strobe(bus_if.wr_strobe), .rd_strobe(bus_if.rd_strobe),
      .wdata(bus_if.wdata), .rdata(bus_if.rdata),
      .rdata_valid(bus_if.rdata_valid), .eot(bus_if.eot),
      .dma_active(bus_if.dma_active));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task op(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk);
      req <= 1'b1;
      cmd <= c;
      din <= d;
      @(posedge clk);
      req <= 1'b0;
      for (int i = 0; i < 8 && done !== 1'b1; i++)
         @(posedge clk);
      repeat (3) @(posedge clk);
      chk({15'h0, busy}, 16'h0000);
   endtask : op
   task bytes(input int n);
      repeat (n)
      begin
         @(posedge clk);
         byte_in <= 1'b1;
         @(posedge clk);
         byte_in <= 1'b0;
      end
      repeat (3) @(posedge clk);
   endtask : bytes
   task t_count;
      op(8'hf3, 16'h0000);
      chk(dout, 16'h0000);
      op(8'hf2, 16'h0005);
      op(8'hf0, 16'h8008);
      chk({15'h0, en}, 16'h0001);
      chk(remain, 16'h0005);
      bytes(3);
      op(8'hf3, 16'h0000);
      chk(dout, 16'h0002);
      bytes(4);
      chk(remain, 16'h0000);
      chk({15'h0, eot_out}, 16'h0001);
   endtask : t_count
   task t_bus_reset;
      @(posedge clk);
      bus_rst <= 1'b1;
      @(posedge clk);
      bus_rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk({15'h0, en}, 16'h0000);
      op(8'hf0, 16'h8008);
      chk(remain, 16'h0005);
   endtask : t_bus_reset
   task t_soft_reset;
      op(8'hf6, 16'h0000);
      chk({15'h0, en}, 16'h0000);
      op(8'hf1, 16'h0000);
      chk(dout, 16'h0000);
      op(8'hf0, 16'h0008);
      chk(remain, 16'h0000);
   endtask : t_soft_reset
   task finish_test;
      $display("mismatches %0d tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      #100000;
      mismatches++;
      finish_test();
   end
   initial
   begin
      {rst, req, byte_in, bus_rst, cmd, din} = {1'b1, 28'h0};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_count();
      t_bus_reset();
      t_soft_reset();
      finish_test();
   end
endmodule : usb_device_dma_byte_counter_tb_top

// ---- rtl/dma_cmd_if.sv ----
`timescale 1ns/100ps
// Shared command/data bus between microprocessor and device controller.
interface dma_cmd_if;
   logic cmd_phase;
   logic wr_strobe;
   logic rd_strobe;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic rdata_valid;
   logic dma_byte;
   logic eot;
   logic dma_active;
   modport device (
      input cmd_phase, wr_strobe, rd_strobe, wdata, dma_byte,
      output rdata, rdata_valid, eot, dma_active
   );
   modport host (
      output cmd_phase, wr_strobe, rd_strobe, wdata, dma_byte,
      input rdata, rdata_valid, eot, dma_active
   );
endinterface : dma_cmd_if

// ---- rtl/dma_counter_cfg.svh ----
`ifndef DMA_COUNTER_CFG_SVH
`define DMA_COUNTER_CFG_SVH

// =============================================================
// Command codes
`define CMD_CONFIG_WRITE 8'hf0
`define CMD_CONFIG_READ 8'hf1
`define CMD_COUNTER_WRITE 8'hf2
`define CMD_COUNTER_READ 8'hf3
`define CMD_DEVICE_RESET 8'hf6

// =============================================================
// Field positions and reset values
`define DMA_ENABLE_POS 3
`define COUNT_END_ENABLE_POS 15
`define COUNTER_RESET 16'h0000
`define CONFIG_RESET 16'h0000

`endif

// ---- rtl/dma_counter_dev.sv ----
`timescale 1ns/100ps
`include "dma_counter_cfg.svh"
//
// Contract
// [R1] Counter write sets next transfer length.
// [R2] Counter read returns remaining byte count.
// [R3] USB bus reset keeps programmed count.
// [R4] Enable set again reloads working counter.
// [R5] F2 writes counter, F3 reads it.
// [R6] One 16-bit word follows; resets zero.
// [R7] F6 resets controller, no data.
// [R8] Reset command equals hardware reset.
// [R9] Enable starts, clear stops; bus reset clears.
// [R10] Count-end enable raises end at zero.
// [R11] Decrement per DMA byte, hold at zero.
module dma_counter_dev
   import dma_counter_pkg::*;
#(
   // Width of the byte counter and of each data word on the bus.
   parameter int COUNT_W = 16,
   // Bit of the configuration word that enables DMA.
   parameter int ENABLE_BIT = `DMA_ENABLE_POS,
   // Bit of the configuration word that enables end of transfer.
   parameter int COUNT_END_BIT = `COUNT_END_ENABLE_POS
)
(
   input wire logic CORE_CLK_I,
   input wire logic RESET_I,
   input wire logic USB_BUS_RESET_I,
   dma_cmd_if.device bus,
   output logic DMA_ENABLE_O,
   output logic [15:0] REMAINING_O
);

   phase_t phase_q;
   logic [7:0] cmd_q;
   word_t dma_byte_counter_q;
   word_t work_q;
   word_t config_q;
   logic soft_rst_q;
   logic rst;
   logic en_prev_q;
   logic dma_enable_bit;
   logic count_end_enable;
   logic read_take;

   // =============================================================
   // Parameter checks
   // The bus moves one full counter value per data phase, so the
   // counter must be exactly as wide as the data bus.
   if (COUNT_W != 16)
   begin : g_bad_count_w
      $error("COUNT_W must equal the 16-bit data bus width");
   end
   // Both enable bits must lie inside the configuration word.
   if (ENABLE_BIT < 0 || ENABLE_BIT >= COUNT_W)
   begin : g_bad_enable_bit
      $error("ENABLE_BIT lies outside the configuration word");
   end
   if (COUNT_END_BIT < 0 || COUNT_END_BIT >= COUNT_W)
   begin : g_bad_count_end_bit
      $error("COUNT_END_BIT lies outside the configuration word");
   end
   // One bit cannot serve as both enables.
   if (ENABLE_BIT == COUNT_END_BIT)
   begin : g_same_bits
      $error("ENABLE_BIT and COUNT_END_BIT must differ");
   end

   // =============================================================
   // Decoding helpers
   // A data word is a write strobe without the command flag, inside
   // the data phase that follows the given command code.
   function automatic logic data_write(
      input phase_t ph,
      input logic wr,
      input logic cp,
      input logic [7:0] cmd,
      input logic [7:0] code
   );
      return ph == PH_DATA && wr && !cp && cmd == code;
   endfunction : data_write

   // Unknown read commands still consume their word but answer zero.
   function automatic word_t read_mux(
      input logic [7:0] cmd,
      input word_t work,
      input word_t cfg
   );
      word_t res;
      res = 16'h0000;
      if (cmd == `CMD_COUNTER_READ)
         res = work;
      else if (cmd == `CMD_CONFIG_READ)
         res = cfg;
      return res;
   endfunction : read_mux

   // Soft reset acts as an extra asynchronous reset for one cycle.
   // It comes from a flip-flop, so the combined reset cannot glitch.
   assign rst = RESET_I | soft_rst_q; // see [R8]
   assign dma_enable_bit = config_q[ENABLE_BIT];
   assign count_end_enable = config_q[COUNT_END_BIT];
   assign read_take = phase_q == PH_DATA && bus.rd_strobe;

   // =============================================================
   // Command decoding
   always_ff @(posedge CORE_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         soft_rst_q <= 1'b0;
      else
         soft_rst_q <= bus.wr_strobe && bus.cmd_phase &&
            bus.wdata[7:0] == `CMD_DEVICE_RESET; // see [R7]
   end

   always_ff @(posedge CORE_CLK_I or posedge rst)
   begin
      if (rst)
      begin
         phase_q <= PH_IDLE;
         cmd_q <= 8'h00;
      end
      else if (bus.cmd_phase && bus.wr_strobe)
      begin
         cmd_q <= bus.wdata[7:0];
         // Reset command takes no data phase.
         phase_q <= (bus.wdata[7:0] == `CMD_DEVICE_RESET) ? PH_IDLE
            : PH_DATA; // see [R7]
      end
      else if (phase_q == PH_DATA && (bus.wr_strobe || bus.rd_strobe))
         phase_q <= PH_IDLE; // see [R6]
   end

   // =============================================================
   // Registers
   always_ff @(posedge CORE_CLK_I or posedge rst)
   begin
      if (rst)
         dma_byte_counter_q <= `COUNTER_RESET; // see [R6]
      else if (data_write(phase_q, bus.wr_strobe, bus.cmd_phase, cmd_q,
               `CMD_COUNTER_WRITE))
         dma_byte_counter_q <= bus.wdata; // see [R1] see [R5] see [R3]
   end

   always_ff @(posedge CORE_CLK_I or posedge rst)
   begin
      if (rst)
         config_q <= `CONFIG_RESET;
      else if (USB_BUS_RESET_I)
         config_q[ENABLE_BIT] <= 1'b0; // see [R9]
      else if (data_write(phase_q, bus.wr_strobe, bus.cmd_phase, cmd_q,
               `CMD_CONFIG_WRITE))
         config_q <= bus.wdata;
   end

   always_ff @(posedge CORE_CLK_I or posedge rst)
   begin
      if (rst)
         en_prev_q <= 1'b0;
      else
         en_prev_q <= dma_enable_bit;
   end

   always_ff @(posedge CORE_CLK_I or posedge rst)
   begin
      if (rst)
         work_q <= `COUNTER_RESET;
      else if (dma_enable_bit && !en_prev_q)
         work_q <= dma_byte_counter_q; // see [R4]
      else if (dma_enable_bit && bus.dma_byte && work_q != 16'h0000)
         work_q <= work_q - 16'h0001; // see [R11]
   end

   // =============================================================
   // Outputs
   // Read answer: data stands until the next read takes its place.
   always_ff @(posedge CORE_CLK_I or posedge rst)
   begin
      if (rst)
      begin
         bus.rdata <= 16'h0000;
         bus.rdata_valid <= 1'b0;
      end
      else
      begin
         bus.rdata_valid <= read_take;
         if (read_take)
            bus.rdata <= read_mux(cmd_q, work_q, config_q); // see [R2]
      end
   end

   // End of transfer waits for the reload, so a stale zero count
   // from before the enable cannot end the new transfer at once.
   always_ff @(posedge CORE_CLK_I or posedge rst)
   begin
      if (rst)
         bus.eot <= 1'b0;
      else
         bus.eot <= count_end_enable && dma_enable_bit && en_prev_q &&
            work_q == 16'h0000; // see [R10]
   end

   // Status seen by the bus and by the pins.
   always_ff @(posedge CORE_CLK_I or posedge rst)
   begin
      if (rst)
      begin
         bus.dma_active <= 1'b0;
         DMA_ENABLE_O <= 1'b0;
         REMAINING_O <= 16'h0000;
      end
      else
      begin
         bus.dma_active <= dma_enable_bit; // see [R9]
         DMA_ENABLE_O <= dma_enable_bit;
         REMAINING_O <= work_q;
      end
   end

endmodule : dma_counter_dev

// ---- rtl/dma_counter_host.sv ----
`timescale 1ns/100ps
`include "dma_counter_cfg.svh"
// Microprocessor end: issues one command and, when needed, one data word.
module dma_counter_host
   import dma_counter_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic RESET_I,
   input wire logic REQ_I,
   input wire logic [7:0] CMD_I,
   input wire logic [15:0] DATA_I,
   input wire logic BYTE_I,
   dma_cmd_if.host bus,
   output logic BUSY_O,
   output logic DONE_O,
   output logic [15:0] DATA_O,
   output logic EOT_O
);

   phase_t state_q;
   logic [7:0] cmd_q;
   logic [15:0] data_q;
   logic is_read;

   assign is_read = cmd_q == `CMD_COUNTER_READ ||
      cmd_q == `CMD_CONFIG_READ; // see [R5]

   always_ff @(posedge CORE_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         state_q <= PH_IDLE;
         cmd_q <= 8'h00;
         data_q <= 16'h0000;
         bus.cmd_phase <= 1'b0;
         bus.wr_strobe <= 1'b0;
         bus.rd_strobe <= 1'b0;
         bus.wdata <= 16'h0000;
         bus.dma_byte <= 1'b0;
         BUSY_O <= 1'b0;
         DONE_O <= 1'b0;
         DATA_O <= 16'h0000;
         EOT_O <= 1'b0;
      end
      else
      begin
         bus.cmd_phase <= 1'b0;
         bus.wr_strobe <= 1'b0;
         bus.rd_strobe <= 1'b0;
         bus.dma_byte <= BYTE_I;
         DONE_O <= 1'b0;
         EOT_O <= bus.eot;
         if (bus.rdata_valid)
            DATA_O <= bus.rdata;
         case (state_q)
            PH_IDLE:
            begin
               if (REQ_I)
               begin
                  cmd_q <= CMD_I;
                  data_q <= DATA_I;
                  bus.cmd_phase <= 1'b1;
                  bus.wr_strobe <= 1'b1;
                  bus.wdata <= {8'h00, CMD_I};
                  // Reset command carries no data word.
                  state_q <= (CMD_I == `CMD_DEVICE_RESET) ? PH_IDLE
                     : PH_DATA; // see [R7]
                  BUSY_O <= CMD_I != `CMD_DEVICE_RESET;
                  DONE_O <= CMD_I == `CMD_DEVICE_RESET;
               end
            end
            PH_DATA:
            begin
               bus.wr_strobe <= !is_read;
               bus.rd_strobe <= is_read;
               bus.wdata <= data_q; // see [R1] see [R6]
               state_q <= PH_IDLE;
               BUSY_O <= 1'b0;
               DONE_O <= 1'b1;
            end
            default:
               state_q <= PH_IDLE;
         endcase
      end
   end

endmodule : dma_counter_host

// ---- rtl/dma_counter_pkg.sv ----
package dma_counter_pkg;
   typedef enum logic [1:0]
   {
      PH_IDLE = 2'b00,
      PH_DATA = 2'b01
   } phase_t;
   typedef logic [15:0] word_t;
endpackage : dma_counter_pkg
